// ---- logic/dic_ctrl.sv ----
// The placing of the registers and register access over APB were chosen for this implementation.
module dic_ctrl #(
  parameter int unsigned STACK_DEPTH = dic_pkg::STACK_DEPTH
) (
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Request pins, active low; shared_pins_irq is active high
  input  wire logic        ext_req_general_n,
  input  wire logic        ext_req_level_zero_n,
  input  wire logic        ext_req_level_one_n,
  input  wire logic        ext_req_edge_n,
  input  wire logic        shared_req_zero_n,
  input  wire logic        shared_req_one_n,
  input  wire logic        shared_pins_irq,
  // Internal sources, one-cycle pulses
  input  wire logic        timer_evt,
  input  wire logic        dma_evt,
  input  wire logic        sp0_tx_evt,
  input  wire logic        sp0_rx_evt,
  input  wire logic        sp1_tx_evt,
  input  wire logic        sp1_rx_evt,
  input  wire logic        powerdown_evt,
  input  wire logic        powerup_context_bit,
  // Sequencer side
  input  wire logic        int_ack,
  input  wire logic        int_return,
  input  wire logic [15:0] status_in,
  output logic             int_req,
  output logic      [13:0] int_vector,
  output logic      [15:0] status_out,
  output logic             stack_overflow
);

  // The stack pointer is four bits wide, so deeper stacks cannot be tracked.
  if (STACK_DEPTH < 2 || STACK_DEPTH > 15)
  begin : g_bad_depth
    $error("dic_ctrl: STACK_DEPTH out of range");
  end

  typedef struct packed {
    logic [10:0] mask;
    logic [4:0]  ctrl;
    logic [10:0] latch;
    logic        glb_en;
    logic        blk;
    logic [15:0] mode;
    logic [3:0]  sp;
    logic [10:0] active;
    logic [6:0]  s1;
    logic [6:0]  s2;
    logic [6:0]  s3;
    logic        boot;
    logic        req;
    logic [13:0] vec;
    logic [3:0]  idx;
    logic [31:0] rdata;
    logic        ready;
    logic        ovf;
    logic [15:0] pop;
  } dic_state_t;

  dic_state_t r, next_r;
  logic [15:0] stack [STACK_DEPTH];

  function automatic logic [13:0] vec_of(input logic [3:0] i);
    case (i)
      4'hA: vec_of = dic_pkg::VEC_PWD;
      4'h9: vec_of = dic_pkg::VEC_GEN;
      4'h8: vec_of = dic_pkg::VEC_LVL1;
      4'h7: vec_of = dic_pkg::VEC_LVL0;
      4'h6: vec_of = dic_pkg::VEC_SP0TX;
      4'h5: vec_of = dic_pkg::VEC_SP0RX;
      4'h4: vec_of = dic_pkg::VEC_EDGE;
      4'h3: vec_of = dic_pkg::VEC_DMA;
      4'h2: vec_of = dic_pkg::VEC_SP1TX;
      4'h1: vec_of = dic_pkg::VEC_SP1RX;
      default: vec_of = dic_pkg::VEC_TMR;
    endcase
  endfunction : vec_of

  //////////////////////////////////////////////////////////////////////////////

  logic [10:0] pend;
  logic [10:0] eff;
  logic [10:0] rise;
  logic [10:0] evts;
  logic [10:0] lvl;
  logic [10:0] edge_mode;
  logic [10:0] svc_bit;
  logic        wr;
  logic        rd;
  logic        sel_found;
  logic [3:0]  sel;
  logic [3:0]  top_act;
  logic        push;

  always_comb
  begin
    // Pin levels after synchronisation, active high.
    lvl = '0;
    lvl[dic_pkg::S_GEN]   = ~r.s2[0];
    lvl[dic_pkg::S_LVL0]  = ~r.s2[1];
    lvl[dic_pkg::S_LVL1]  = ~r.s2[2];
    lvl[dic_pkg::S_EDGE]  = ~r.s2[3];
    lvl[dic_pkg::S_SP1RX] = ~r.s2[4] & r.s2[6];
    lvl[dic_pkg::S_SP1TX] = ~r.s2[5] & r.s2[6];
    edge_mode = '0;
    edge_mode[dic_pkg::S_EDGE]  = 1'b1;
    edge_mode[dic_pkg::S_PWD]   = 1'b1;
    edge_mode[dic_pkg::S_GEN]   = r.ctrl[dic_pkg::C_EDGE_GEN];
    edge_mode[dic_pkg::S_SP1RX] = r.ctrl[dic_pkg::C_EDGE_SH0];
    edge_mode[dic_pkg::S_SP1TX] = r.ctrl[dic_pkg::C_EDGE_SH1];
    rise = '0;
    rise[dic_pkg::S_GEN]   = r.s3[0] & ~r.s2[0];
    rise[dic_pkg::S_EDGE]  = r.s3[3] & ~r.s2[3];
    rise[dic_pkg::S_SP1RX] = r.s3[4] & ~r.s2[4] & r.s2[6];
    rise[dic_pkg::S_SP1TX] = r.s3[5] & ~r.s2[5] & r.s2[6];
    // Internal events are always latched, whatever the pin sense bits say.
    evts = '0;
    evts[dic_pkg::S_TMR]   = timer_evt;
    evts[dic_pkg::S_DMA]   = dma_evt;
    evts[dic_pkg::S_SP0TX] = sp0_tx_evt;
    evts[dic_pkg::S_SP0RX] = sp0_rx_evt;
    evts[dic_pkg::S_SP1TX] = sp1_tx_evt;
    evts[dic_pkg::S_SP1RX] = sp1_rx_evt;
    evts[dic_pkg::S_PWD]   = powerdown_evt;
    wr = psel & penable & pwrite & r.ready;
    rd = psel & ~penable & ~pwrite;
    pend = r.latch | (lvl & ~edge_mode);
    eff = pend & (r.mask | (11'h001 << dic_pkg::S_PWD));
    sel_found = 1'b0;
    sel = '0;
    for (int i = 0; i < int'(dic_pkg::NSRC); i++)
    begin
      if (eff[i])
      begin
        sel_found = 1'b1;
        sel = 4'(i);
      end
    end
    top_act = '0;
    for (int i = 0; i < int'(dic_pkg::NSRC); i++)
    begin
      if (r.active[i])
        top_act = 4'(i);
    end
    next_r = r;
    next_r.s1 = {shared_pins_irq, shared_req_one_n, shared_req_zero_n, ext_req_edge_n,
                 ext_req_level_one_n, ext_req_level_zero_n, ext_req_general_n};
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    next_r.blk = 1'b0;
    next_r.boot = 1'b0;
    next_r.ready = 1'b0;
    next_r.ovf = 1'b0;
    // Events win over a clear in the same cycle.
    svc_bit = '0;
    push = 1'b0;
    next_r.req = 1'b0;
    // A mask write also holds off the grant in its own cycle, so the old mask is never used.
    if (r.glb_en && !r.blk && sel_found && !r.req && !r.boot &&
        !(wr && paddr == dic_pkg::A_MASK) && !(r.boot && powerup_context_bit) &&
        (r.active == '0 || (r.ctrl[dic_pkg::C_NEST] && sel > top_act)))
    begin
      next_r.req = 1'b1;
      next_r.vec = vec_of(sel);
      next_r.idx = sel;
    end
    if (r.req && !int_ack)
    begin
      next_r.req = 1'b1;
    end
    if (r.req && int_ack)
    begin
      svc_bit[r.idx] = 1'b1;
      push = 1'b1;
      next_r.active[r.idx] = 1'b1;
      if (r.sp < 4'(STACK_DEPTH))
        next_r.sp = r.sp + 4'h1;
      else
        next_r.ovf = 1'b1;
    end
    if (int_return && r.active != '0)
    begin
      next_r.active[top_act] = 1'b0;
      if (r.sp != 4'h0)
      begin
        next_r.sp = r.sp - 4'h1;
        next_r.pop = stack[r.sp - 4'h1];
      end
    end
    next_r.latch = r.latch & ~svc_bit;
    if (wr && paddr == dic_pkg::A_FORCE)
      next_r.latch = (next_r.latch | pwdata[10:0]) &
                     ~pwdata[dic_pkg::F_CLR_LSB +: 11];
    next_r.latch = next_r.latch | (rise & edge_mode) | evts;
    if (wr)
    begin
      case (paddr)
        dic_pkg::A_MASK:
        begin
          next_r.mask = pwdata[10:0];
          next_r.blk = 1'b1;
        end
        dic_pkg::A_CTRL:   next_r.ctrl = pwdata[4:0];
        dic_pkg::A_GLOBAL: next_r.glb_en = pwdata[0];
        dic_pkg::A_MODE:   next_r.mode = pwdata[15:0];
        default: next_r.mode = r.mode;
      endcase
    end
    if (psel && !penable)
    begin
      next_r.ready = 1'b1;
      next_r.rdata = '0;
      if (rd)
      begin
        case (paddr)
          dic_pkg::A_MASK:   next_r.rdata = {21'h0, r.mask};
          dic_pkg::A_CTRL:   next_r.rdata = {27'h0, r.ctrl};
          dic_pkg::A_PEND:   next_r.rdata = {21'h0, pend};
          dic_pkg::A_GLOBAL: next_r.rdata = {31'h0, r.glb_en};
          dic_pkg::A_STAT:   next_r.rdata = {4'h0, r.idx, r.sp, 9'h000, r.active};
          dic_pkg::A_MODE:   next_r.rdata = {16'h0, r.mode};
          default:           next_r.rdata = '0;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  // Request pins are asynchronous, so they pass s1 and s2 before use.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r        <= '0;
      r.mask   <= dic_pkg::MASK_RESET;
      r.ctrl   <= dic_pkg::CTRL_RESET;
      r.mode   <= dic_pkg::MODE_RESET;
      r.glb_en <= 1'b1;
      r.s1     <= 7'h3F;
      r.s2     <= 7'h3F;
      r.s3     <= 7'h3F;
      r.boot   <= 1'b1;
      r.vec    <= dic_pkg::VEC_RESET;
    end
    else
    begin
      r <= next_r;
    end
  end

  always_ff @(posedge pclk)
  begin
    if (push && r.sp < 4'(STACK_DEPTH))
      stack[r.sp] <= status_in;
  end

  //////////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    prdata         = r.rdata;
    pready         = r.ready;
    pslverr        = 1'b0;
    int_req        = r.req;
    int_vector     = r.vec;
    status_out     = r.pop;
    stack_overflow = r.ovf;
  end

  //////////////////////////////////////////////////////////////////////////////

  property p_mask_block;
    @(posedge pclk) disable iff (!presetn)
      (wr && paddr == dic_pkg::A_MASK) |=> !$rose(r.req);
  endproperty
  a_mask_block: assert property (p_mask_block) else $error("request after mask write");

  property p_global_off;
    @(posedge pclk) disable iff (!presetn)
      !r.glb_en && !r.req |=> !r.req;
  endproperty
  a_global_off: assert property (p_global_off) else $error("request while disabled");

  property p_masked;
    @(posedge pclk) disable iff (!presetn)
      $rose(r.req) |-> r.mask[r.idx] || r.idx == 4'(dic_pkg::S_PWD);
  endproperty
  a_masked: assert property (p_masked) else $error("masked source requested");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
      r.req && !int_ack |=> r.req && $stable(r.vec);
  endproperty
  a_hold: assert property (p_hold) else $error("request dropped");

  property p_vec;
    @(posedge pclk) disable iff (!presetn)
      r.req |-> r.vec == vec_of(r.idx);
  endproperty
  a_vec: assert property (p_vec) else $error("wrong vector");

  property p_push;
    @(posedge pclk) disable iff (!presetn)
      r.req && int_ack && !int_return && r.sp < 4'(STACK_DEPTH) |=> r.sp == $past(r.sp) + 4'h1;
  endproperty
  a_push: assert property (p_push) else $error("stack not pushed");

  property p_seq;
    @(posedge pclk) disable iff (!presetn)
      !r.ctrl[dic_pkg::C_NEST] && r.active != '0 && !int_return |=> !$rose(r.req);
  endproperty
  a_seq: assert property (p_seq) else $error("nested while sequential");

  property p_edge_latch;
    @(posedge pclk) disable iff (!presetn)
      dma_evt |=> r.latch[dic_pkg::S_DMA];
  endproperty
  a_edge_latch: assert property (p_edge_latch) else $error("edge event lost");

endmodule : dic_ctrl

// ---- logic/dic_pkg.sv ----
// Operation
// - Eleven interrupt sources plus master reset are handled with little overhead.
// - Four dedicated external request pins; two more when second serial port reconfigured.
// - Internal requests come from timer, byte DMA, both serial ports, software, power-down.
// - Fixed priorities; each source maskable except power-down and reset.
// - General, shared one and shared zero requests are programmable level or edge.
// - Both dedicated level request pins are always level sensitive.
// - Dedicated edge request is always edge sensitive; software may force or clear it.
// - Reset vectors to 0000 at top priority; power-up with context bit too (here powerup_context_bit has no effect; only presetn loads 0000).
// - Power-down 002C, general 0004, level one 0008, level zero 000C, timer 0028 lowest.
// - Second port transmit and shared request one share vector 0020.
// - Second port receive and shared request zero share vector 0024.
// - Control register selects nested or strictly sequential servicing.
// - Pending requests ANDed with mask; highest unmasked request is serviced.
// - A mask write blocks all interrupts for one instruction cycle.
// - Control register holds nesting enable and three level-or-edge selections.
// - Write-only force/clear register sets or clears individual pending requests.
// - Status stack is twelve levels deep, pushed on accept, popped on return.
// - Global enable and disable gate all servicing, power-down included, ignoring mask.
// - After reset global servicing is enabled.
// - Reset empties stack, masks every source and clears the mode status register.
package dic_pkg;

  localparam int unsigned NSRC = 11;

  // Source indices, highest priority is index 10.
  localparam int unsigned S_PWD   = 10;
  localparam int unsigned S_GEN   = 9;
  localparam int unsigned S_LVL1  = 8;
  localparam int unsigned S_LVL0  = 7;
  localparam int unsigned S_SP0TX = 6;
  localparam int unsigned S_SP0RX = 5;
  localparam int unsigned S_EDGE  = 4;
  localparam int unsigned S_DMA   = 3;
  localparam int unsigned S_SP1TX = 2;
  localparam int unsigned S_SP1RX = 1;
  localparam int unsigned S_TMR   = 0;

  localparam logic [13:0] VEC_RESET = 14'h0000;
  localparam logic [13:0] VEC_PWD   = 14'h002C;
  localparam logic [13:0] VEC_GEN   = 14'h0004;
  localparam logic [13:0] VEC_LVL1  = 14'h0008;
  localparam logic [13:0] VEC_LVL0  = 14'h000C;
  localparam logic [13:0] VEC_SP0TX = 14'h0010;
  localparam logic [13:0] VEC_SP0RX = 14'h0014;
  localparam logic [13:0] VEC_EDGE  = 14'h0018;
  localparam logic [13:0] VEC_DMA   = 14'h001C;
  localparam logic [13:0] VEC_SP1TX = 14'h0020;
  localparam logic [13:0] VEC_SP1RX = 14'h0024;
  localparam logic [13:0] VEC_TMR   = 14'h0028;

  localparam int unsigned STACK_DEPTH = 12;

  // APB byte addresses.
  localparam logic [7:0] A_MASK   = 8'h00;
  localparam logic [7:0] A_CTRL   = 8'h04;
  localparam logic [7:0] A_FORCE  = 8'h08;
  localparam logic [7:0] A_PEND   = 8'h0C;
  localparam logic [7:0] A_GLOBAL = 8'h10;
  localparam logic [7:0] A_STAT   = 8'h14;
  localparam logic [7:0] A_MODE   = 8'h18;

  // Control register fields.
  localparam int unsigned C_EDGE_SH0 = 0;
  localparam int unsigned C_EDGE_SH1 = 1;
  localparam int unsigned C_EDGE_GEN = 2;
  localparam int unsigned C_NEST     = 4;

  // Force/clear register: force in bits 10:0, clear in bits 26:16.
  localparam int unsigned F_CLR_LSB = 16;

  localparam logic [10:0] MASK_RESET = 11'h000;
  localparam logic [4:0]  CTRL_RESET = 5'h00;
  localparam logic [15:0] MODE_RESET = 16'h0000;

endpackage : dic_pkg

// ---- tb/dic_pins_model.sv ----
module dic_pins_model (
  // Clock
  input  wire logic       pclk,
  // Requests asked for by the bench
  input  wire logic [5:0] req_on,
  // Active-low pins
  output logic      [5:0] req_pins_n
);
  timeunit 1ns;
  timeprecision 1ns;

  // The pins have pull-ups, so a released line reads high.
  initial req_pins_n = 6'h3F;

  always @(posedge pclk)
  begin
    req_pins_n <= ~req_on;
  end
endmodule : dic_pins_model

// ---- tb/testbench.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct {int src; logic [13:0] vec;} dic_row_t;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic [10:0] evt;
  logic [5:0]  pin_on;
  logic [5:0]  pin_n;
  logic        shared_on;
  logic        int_ack;
  logic        int_return;
  logic [15:0] status_in;
  logic        int_req;
  logic [13:0] int_vector;
  logic [15:0] status_out;
  logic [15:0] sq[$];
  logic [31:0] rd;
  int          error_cnt;
  int          check_count;
  int          cyc;
  dic_row_t    rows[7] = '{'{0, 14'h0028}, '{1, 14'h0024}, '{2, 14'h0020}, '{3, 14'h001C},
                           '{5, 14'h0014}, '{6, 14'h0010}, '{10, 14'h002C}};

  ////////////////////////////////////////////////////////////////////////////////
  dic_pins_model dic_pins_model_inst (.pclk(pclk), .req_on(pin_on), .req_pins_n(pin_n));

  dic_ctrl dic_ctrl_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(),
    .ext_req_general_n(pin_n[0]), .ext_req_level_zero_n(pin_n[1]),
    .ext_req_level_one_n(pin_n[2]), .ext_req_edge_n(pin_n[3]),
    .shared_req_zero_n(pin_n[4]), .shared_req_one_n(pin_n[5]), .shared_pins_irq(shared_on),
    .timer_evt(evt[0]), .sp1_rx_evt(evt[1]), .sp1_tx_evt(evt[2]), .dma_evt(evt[3]),
    .sp0_rx_evt(evt[5]), .sp0_tx_evt(evt[6]), .powerdown_evt(evt[10]),
    .powerup_context_bit(1'h0), .int_ack(int_ack), .int_return(int_return),
    .status_in(status_in), .int_req(int_req), .int_vector(int_vector),
    .status_out(status_out), .stack_overflow());

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'h0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish;
    if (error_cnt == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  // The wait for pready is bounded at 50 cycles; with a dead slave the access then goes on and no error is counted.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(negedge pclk);
    while (pready !== 1'h1 && n < 50)
    begin
      @(negedge pclk);
      n++;
    end
    rd = prdata;
    @(posedge pclk);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic pulse(input logic [10:0] m);
    @(posedge pclk);
    evt <= m;
    @(posedge pclk);
    evt <= 11'h000;
  endtask : pulse

  // Level pins are dropped once the request is seen, so none re-fires after return.
  task automatic take(input logic [13:0] v);
    int n;
    n = 0;
    while (int_req !== 1'h1 && n < 40)
    begin
      @(posedge pclk);
      n++;
    end
    pin_on <= 6'h00;
    chk({17'h0, int_req, int_vector}, {17'h0, 1'h1, v});
    status_in <= {2'h0, v};
    sq.push_back({2'h0, v});
    int_ack <= 1'h1;
    @(posedge pclk);
    int_ack <= 1'h0;
  endtask : take

  task automatic ret;
    repeat (4) @(posedge pclk);
    int_return <= 1'h1;
    @(posedge pclk);
    int_return <= 1'h0;
    repeat (2) @(posedge pclk);
    chk({16'h0, status_out}, {16'h0, sq.pop_back()});
  endtask : ret

  task automatic quiet;
    repeat (10) @(posedge pclk);
    chk({31'h0, int_req}, 32'h0);
  endtask : quiet

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      tally_and_finish;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, evt, pin_on} = '0;
    {shared_on, int_ack, int_return, status_in, error_cnt, check_count, cyc} = '0;
    presetn = 1'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h1, dic_pkg::A_MASK, 32'h7FF);
    foreach (rows[i])
    begin
      pulse(11'(1 << rows[i].src));
      take(rows[i].vec);
      ret;
    end
    pulse(11'h009);
    take(14'h001C);
    ret;
    take(14'h0028);
    ret;
    pulse(11'h001);
    take(14'h0028);
    pulse(11'h008);
    quiet;
    ret;
    take(14'h001C);
    ret;
    apb(1'h1, dic_pkg::A_CTRL, 32'h10);
    pulse(11'h001);
    take(14'h0028);
    pulse(11'h008);
    take(14'h001C);
    ret;
    ret;
    pin_on <= 6'h02;
    take(14'h000C);
    ret;
    pin_on <= 6'h04;
    take(14'h0008);
    ret;
    pin_on <= 6'h01;
    take(14'h0004);
    ret;
    apb(1'h1, dic_pkg::A_CTRL, 32'h14);
    pin_on <= 6'h01;
    repeat (4) @(posedge pclk);
    pin_on <= 6'h00;
    take(14'h0004);
    ret;
    quiet;
    pin_on <= 6'h08;
    repeat (4) @(posedge pclk);
    pin_on <= 6'h00;
    take(14'h0018);
    ret;
    shared_on <= 1'h1;
    pin_on <= 6'h10;
    take(14'h0024);
    ret;
    pin_on <= 6'h20;
    take(14'h0020);
    ret;
    apb(1'h1, dic_pkg::A_MASK, 32'h0);
    pulse(11'h001);
    quiet;
    apb(1'h1, dic_pkg::A_MASK, 32'h1);
    take(14'h0028);
    ret;
    pulse(11'h400);
    take(14'h002C);
    ret;
    apb(1'h1, dic_pkg::A_GLOBAL, 32'h0);
    apb(1'h1, dic_pkg::A_MASK, 32'h7FF);
    pulse(11'h400);
    quiet;
    apb(1'h1, dic_pkg::A_GLOBAL, 32'h1);
    take(14'h002C);
    ret;
    apb(1'h1, dic_pkg::A_MASK, 32'h0);
    apb(1'h1, dic_pkg::A_FORCE, 32'h10);
    apb(1'h0, dic_pkg::A_PEND, 32'h0);
    chk(rd, 32'h10);
    apb(1'h1, dic_pkg::A_FORCE, 32'h100000);
    apb(1'h0, dic_pkg::A_PEND, 32'h0);
    chk(rd, 32'h0);
    apb(1'h0, 8'hFC, 32'h0);
    chk(rd, 32'h0);
    apb(1'h1, dic_pkg::A_GLOBAL, 32'h0);
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    chk({18'h0, int_vector}, 32'h0);
    presetn <= 1'h1;
    apb(1'h0, dic_pkg::A_MASK, 32'h0);
    chk(rd, 32'h0);
    apb(1'h0, dic_pkg::A_GLOBAL, 32'h0);
    chk(rd, 32'h1);
    apb(1'h0, dic_pkg::A_MODE, 32'h0);
    chk(rd, 32'h0);
    apb(1'h0, dic_pkg::A_STAT, 32'h0);
    chk(rd & 32'h00F00000, 32'h0);
    tally_and_finish;
  end
endmodule : testbench
